/* File: core/tick_map.svh */
// Register offsets, field positions, reset values and sizes of the tick unit
`ifndef TICK_MAP_SVH
`define TICK_MAP_SVH

`define TICK_ADDR_W        8
`define TICK_DATA_W        32
`define TICK_CTRL_OFS      8'h00
`define TICK_STAT_OFS      8'h04
`define TICK_MASK_OFS      8'h08
`define TICK_OPT_OFS       8'h0C

`define TICK_PEND_BIT      7
`define TICK_RATE_MSB      6
`define TICK_RATE_LSB      4
`define TICK_ACK_BIT       3
`define TICK_IE_BIT        2
`define TICK_RUN_BIT       1
`define TICK_STAT_EV_BIT   0
`define TICK_OPT_KEEP_BIT  0

`define TICK_RATE_RST      3'h0
`define TICK_MASK_RST      1'h0
`define TICK_OPT_RST       1'h0
`define TICK_DIV_STAGES    18
`define TICK_CLK_PERIOD_NS 4

`define TICK_RESP_OKAY     2'h0
`define TICK_RESP_SLVERR   2'h2

`endif

/* File: core/tick_pkg.sv */
// Types shared by the periodic tick unit
package tick_pkg;

    typedef logic [2:0] rate_type;

    typedef struct packed {
        rate_type rate;
        logic     irq_en;
        logic     run;
    } ctrl_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       strb;
    } wr_req_type;

endpackage

/* File: core/periodic_tick_unit.sv */
// Periodic tick unit: 18-stage divider, tick flag, AXI4-Lite register slave
// Notes on behaviour
// - Divider steps on oscillator reference clock rising edges.
// - Eighteen binary stages, eight selectable taps.
// - Run bit clear holds divider at zero.
// - Run bit set lets divider advance.
// - Overflow at selected tap sets pending flag.
// - Pending and enable raise CPU interrupt.
// - First tick at half period, then full.
// - Rate field picks divide ratio 262144..8.
// - Pending flag readable, never written directly.
// - Writing one to acknowledge clears pending.
// - Acknowledge stores nothing, reads zero.
// - Interrupt enable read/write, reset clears it.
// - Run bit reset-cleared; toggling restarts divider.
// - Wait mode keeps counting, blocks register access.
// - Stop with oscillator kept: runs, wakes.
// - Stop blocks access; no oscillator, no count.
`timescale 1ns/1ns
`include "tick_map.svh"

module periodic_tick_unit (
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    // Oscillator reference and power modes
    input  wire logic                      osc_reference_clock_i,
    input  wire logic                      wait_mode_i,
    input  wire logic                      stop_mode_i,
    // AXI4-Lite write address and data
    input  wire logic [`TICK_ADDR_W-1:0]   axi_awaddr_i,
    input  wire logic                      axi_awvalid_i,
    output logic                           axi_awready_o,
    input  wire logic [`TICK_DATA_W-1:0]   axi_wdata_i,
    input  wire logic [3:0]                axi_wstrb_i,
    input  wire logic                      axi_wvalid_i,
    output logic                           axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                     axi_bresp_o,
    output logic                           axi_bvalid_o,
    input  wire logic                      axi_bready_i,
    // AXI4-Lite read
    input  wire logic [`TICK_ADDR_W-1:0]   axi_araddr_i,
    input  wire logic                      axi_arvalid_i,
    output logic                           axi_arready_o,
    output logic [`TICK_DATA_W-1:0]        axi_rdata_o,
    output logic [1:0]                     axi_rresp_o,
    output logic                           axi_rvalid_o,
    input  wire logic                      axi_rready_i,
    // Interrupt and wake-up
    output logic                           irq_o,
    output logic                           wake_o
);

    localparam int STAGES = `TICK_DIV_STAGES;

    tick_pkg::ctrl_type         ctrl;
    tick_pkg::ctrl_type         next_ctrl;
    tick_pkg::wr_req_type       wr_req;
    logic                       tick_pending_flag;
    logic                       next_pending;
    logic                       stat_event;
    logic                       next_stat;
    logic                       irq_mask;
    logic                       next_mask;
    logic                       stop_osc_keep;
    logic                       next_keep;
    logic [STAGES-1:0]          count;
    logic [STAGES-1:0]          count_inc;
    logic                       osc_s1;
    logic                       osc_s2;
    logic                       osc_s3;
    logic                       osc_step;
    logic                       advance;
    logic                       ovf_event;
    logic                       aw_full;
    logic                       w_full;
    logic                       wr_go;
    logic                       wr_ok;
    logic                       ack_hit;
    logic                       ar_take;
    logic                       stat_read;
    logic                       bus_blocked;

    // tap decode, 8 of 18 stages
    function automatic logic [4:0] tap_index(input tick_pkg::rate_type rate);
        case (rate)
            3'h0:    tap_index = 5'h11;
            3'h1:    tap_index = 5'h10;
            3'h2:    tap_index = 5'h0F;
            3'h3:    tap_index = 5'h0E;
            3'h4:    tap_index = 5'h05;
            3'h5:    tap_index = 5'h04;
            3'h6:    tap_index = 5'h03;
            default: tap_index = 5'h02;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [`TICK_ADDR_W-1:0] addr);
        if (addr == `TICK_CTRL_OFS) begin
            is_mapped = 1'b1;
        end else if (addr == `TICK_STAT_OFS) begin
            is_mapped = 1'b1;
        end else if (addr == `TICK_MASK_OFS) begin
            is_mapped = 1'b1;
        end else if (addr == `TICK_OPT_OFS) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    endfunction

    assign bus_blocked = wait_mode_i | stop_mode_i;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= osc_reference_clock_i;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // one step per reference rising edge
    assign osc_step = osc_s2 & ~osc_s3;

    // stop runs only with oscillator kept
    assign advance   = ctrl.run & osc_step & ~(stop_mode_i & ~stop_osc_keep);
    assign count_inc = count + 1'b1;

    // tick on rising edge of selected tap
    // tap rises at half period first
    assign ovf_event = advance & ~count[tap_index(ctrl.rate)]
                     & count_inc[tap_index(ctrl.rate)];

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (!ctrl.run) begin
            count <= '0;
        end else if (advance) begin
            count <= count_inc;
        end
    end

    // Write path: address and data taken in either order
    assign wr_go = aw_full & w_full;
    assign wr_ok = wr_go & is_mapped(wr_req.addr) & ~bus_blocked;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            aw_full       <= 1'b0;
            axi_awready_o <= 1'b1;
            wr_req.addr   <= 8'h00;
        end else if (axi_awvalid_i && axi_awready_o) begin
            aw_full       <= 1'b1;
            axi_awready_o <= 1'b0;
            wr_req.addr   <= axi_awaddr_i;
        end else if (wr_go) begin
            aw_full       <= 1'b0;
        end else if (axi_bvalid_o && axi_bready_i) begin
            axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            w_full       <= 1'b0;
            axi_wready_o <= 1'b1;
            wr_req.data  <= 8'h00;
            wr_req.strb  <= 1'b0;
        end else if (axi_wvalid_i && axi_wready_o) begin
            w_full       <= 1'b1;
            axi_wready_o <= 1'b0;
            wr_req.data  <= axi_wdata_i[7:0];
            wr_req.strb  <= axi_wstrb_i[0];
        end else if (wr_go) begin
            w_full       <= 1'b0;
        end else if (axi_bvalid_o && axi_bready_i) begin
            axi_wready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            axi_bvalid_o <= 1'b0;
            axi_bresp_o  <= `TICK_RESP_OKAY;
        end else if (wr_go) begin
            axi_bvalid_o <= 1'b1;
            axi_bresp_o  <= wr_ok ? `TICK_RESP_OKAY : `TICK_RESP_SLVERR;
        end else if (axi_bready_i) begin
            axi_bvalid_o <= 1'b0;
        end
    end

    assign ack_hit = wr_ok & wr_req.strb & (wr_req.addr == `TICK_CTRL_OFS)
                   & wr_req.data[`TICK_ACK_BIT];

    // Read path; a status read is its own clear
    assign ar_take   = axi_arvalid_i & axi_arready_o;
    assign stat_read = ar_take & ~bus_blocked & (axi_araddr_i == `TICK_STAT_OFS);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            axi_arready_o <= 1'b1;
            axi_rvalid_o  <= 1'b0;
            axi_rdata_o   <= 32'h0000_0000;
            axi_rresp_o   <= `TICK_RESP_OKAY;
        end else if (ar_take) begin
            axi_arready_o <= 1'b0;
            axi_rvalid_o  <= 1'b1;
            axi_rdata_o   <= 32'h0000_0000;
            axi_rresp_o   <= `TICK_RESP_OKAY;
            if (bus_blocked || !is_mapped(axi_araddr_i)) begin
                axi_rresp_o <= `TICK_RESP_SLVERR;
            end else if (axi_araddr_i == `TICK_CTRL_OFS) begin
                axi_rdata_o[`TICK_PEND_BIT]                 <= tick_pending_flag;
                axi_rdata_o[`TICK_RATE_MSB:`TICK_RATE_LSB]  <= ctrl.rate;
                axi_rdata_o[`TICK_IE_BIT]                   <= ctrl.irq_en;
                axi_rdata_o[`TICK_RUN_BIT]                  <= ctrl.run;
            end else if (axi_araddr_i == `TICK_STAT_OFS) begin
                axi_rdata_o[`TICK_STAT_EV_BIT] <= stat_event;
            end else if (axi_araddr_i == `TICK_MASK_OFS) begin
                axi_rdata_o[`TICK_STAT_EV_BIT] <= irq_mask;
            end else begin
                axi_rdata_o[`TICK_OPT_KEEP_BIT] <= stop_osc_keep;
            end
        end else if (axi_rvalid_o && axi_rready_i) begin
            axi_arready_o <= 1'b1;
            axi_rvalid_o  <= 1'b0;
        end
    end

    // Next values of the software-visible state
    always_comb begin
        next_ctrl    = ctrl;
        next_mask    = irq_mask;
        next_keep    = stop_osc_keep;
        next_pending = tick_pending_flag;
        next_stat    = stat_event;
        if (wr_ok && wr_req.strb) begin
            if (wr_req.addr == `TICK_CTRL_OFS) begin
                next_ctrl.rate   = wr_req.data[`TICK_RATE_MSB:`TICK_RATE_LSB];
                next_ctrl.irq_en = wr_req.data[`TICK_IE_BIT];
                next_ctrl.run    = wr_req.data[`TICK_RUN_BIT];
            end else if (wr_req.addr == `TICK_MASK_OFS) begin
                next_mask = wr_req.data[`TICK_STAT_EV_BIT];
            end else if (wr_req.addr == `TICK_OPT_OFS) begin
                next_keep = wr_req.data[`TICK_OPT_KEEP_BIT];
            end
        end
        if (ack_hit) begin
            next_pending = 1'b0;
        end
        if (stat_read) begin
            next_stat = 1'b0;
        end
        // a new tick beats the clear
        if (ovf_event) begin
            next_pending = 1'b1;
            next_stat    = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl.rate     <= `TICK_RATE_RST;
            ctrl.irq_en   <= 1'b0;
            ctrl.run      <= 1'b0;
            irq_mask      <= `TICK_MASK_RST;
            stop_osc_keep <= `TICK_OPT_RST;
        end else begin
            ctrl          <= next_ctrl;
            irq_mask      <= next_mask;
            stop_osc_keep <= next_keep;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tick_pending_flag <= 1'b0;
            stat_event        <= 1'b0;
        end else begin
            tick_pending_flag <= next_pending;
            stat_event        <= next_stat;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= (next_pending & next_ctrl.irq_en) | (next_stat & next_mask);
            wake_o <= ovf_event & stop_mode_i;
        end
    end

    // Checks
    a_run_clear_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ctrl.run |=> count == '0)
        else $error("divider not zero while stopped");

    a_tick_sets_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ovf_event |=> tick_pending_flag ##1 (irq_o == ctrl.irq_en || stat_event))
        else $error("tick did not set pending flag");

    a_irq_follows: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (tick_pending_flag && ctrl.irq_en) |-> irq_o)
        else $error("interrupt missing while pending and enabled");

    a_tap_position: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ovf_event |=> count[tap_index(ctrl.rate)] && count[1:0] == 2'h0)
        else $error("tick not at tap half period");

    a_ack_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ack_hit && !ovf_event) |=> !tick_pending_flag)
        else $error("acknowledge did not clear flag");

    a_ack_reads_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        axi_rvalid_o |-> !axi_rdata_o[`TICK_ACK_BIT])
        else $error("acknowledge bit read as one");

    a_no_direct_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!tick_pending_flag && !ovf_event) |=> !tick_pending_flag)
        else $error("pending flag set without tick");

    a_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ack_hit && ovf_event) |=> tick_pending_flag)
        else $error("tick lost against acknowledge");

    a_stop_frozen: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (stop_mode_i && !stop_osc_keep && ctrl.run) |=> $stable(count))
        else $error("divider moved in stop without oscillator");

    a_wait_counts: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wait_mode_i && !stop_mode_i && ctrl.run && osc_step) |=> count != $past(count))
        else $error("divider stalled in wait");

    a_stop_wake: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ovf_event && stop_mode_i) |=> wake_o)
        else $error("no wake on tick in stop");

    a_reset_clears: assert property (@(posedge mclk_i)
        !rst_n_i |=> !ctrl.irq_en && !ctrl.run && !irq_o)
        else $error("reset left enable or run set");

    c_tick_seen: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        ovf_event ##1 irq_o);
    c_set_and_ack: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        ack_hit && ovf_event);
    c_wake: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        wake_o);
    c_restart: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        ctrl.run ##1 !ctrl.run ##1 ctrl.run);

endmodule

/* File: tb/test_periodic_tick_unit.sv */
// Self-checking bench for the periodic tick unit
`timescale 1ns/1ns
`include "tick_map.svh"

module test_periodic_tick_unit;
    typedef struct {
        logic [2:0] rate;
        int         div;
    } row_type;

    logic        mclk    = 1'b0;
    logic        rst_n   = 1'b0;
    logic        osc     = 1'b0;
    logic        wait_m  = 1'b0;
    logic        stop_m  = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h00000000;
    logic [3:0]  wstrb   = 4'hF;
    logic        wvalid  = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready  = 1'b0;
    logic        irq;
    logic        wake;
    logic        ph      = 1'b0;
    int          failures        = 0;
    int          samples_checked = 0;
    int          cycles  = 0;
    int          steps   = 0;
    int          wakes   = 0;
    row_type     rows[8] = '{'{3'h0, 262144}, '{3'h1, 131072}, '{3'h2, 65536},
                             '{3'h3, 32768}, '{3'h4, 64}, '{3'h5, 32},
                             '{3'h6, 16}, '{3'h7, 8}};

    periodic_tick_unit DUT (
        .mclk_i                (mclk),
        .rst_n_i               (rst_n),
        .osc_reference_clock_i (osc),
        .wait_mode_i           (wait_m),
        .stop_mode_i           (stop_m),
        .axi_awaddr_i          (awaddr),
        .axi_awvalid_i         (awvalid),
        .axi_awready_o         (awready),
        .axi_wdata_i           (wdata),
        .axi_wstrb_i           (wstrb),
        .axi_wvalid_i          (wvalid),
        .axi_wready_o          (wready),
        .axi_bresp_o           (bresp),
        .axi_bvalid_o          (bvalid),
        .axi_bready_i          (bready),
        .axi_araddr_i          (araddr),
        .axi_arvalid_i         (arvalid),
        .axi_arready_o         (arready),
        .axi_rdata_o           (rdata),
        .axi_rresp_o           (rresp),
        .axi_rvalid_o          (rvalid),
        .axi_rready_i          (rready),
        .irq_o                 (irq),
        .wake_o                (wake)
    );

    always #2 mclk = ~mclk;

    // Reference at a quarter of mclk, two cycles high and two low
    always @(posedge mclk) begin
        ph <= ~ph;
        if (ph) begin
            osc <= ~osc;
            if (!osc) steps <= steps + 1;
        end
        if (wake === 1'b1) wakes <= wakes + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] cv(input logic [2:0] rt, input logic ack, ie, run);
        return {25'h0, rt, ack, ie, run, 1'b0};
    endfunction

    task automatic wck(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er = `TICK_RESP_OKAY,
                       input logic [3:0] st = 4'hF);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= st;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rck(input logic [7:0] a, input logic [31:0] ed,
                       input logic [1:0] er = `TICK_RESP_OKAY);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
    endtask

    // Absolute step count at which irq is seen high, or -1
    task automatic wait_irq(input int lim, output int at);
        at = -1;
        for (int i = 0; i < lim * 4 + 24 && at < 0; i++) begin
            @(posedge mclk);
            if (irq === 1'b1) at = steps;
        end
    endtask

    initial begin
        int t0;
        int t1;
        int t2;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rck(`TICK_CTRL_OFS, 32'h0);
        rck(`TICK_STAT_OFS, 32'h0);
        foreach (rows[i]) begin
            // Rate set while stopped, in the same write that sets run
            wck(`TICK_CTRL_OFS, cv(rows[i].rate, 1'b0, 1'b1, 1'b1));
            t0 = steps;
            if (rows[i].div > 64) begin
                wait_irq(200, t1);
                chk(t1, -1);
            end else begin
                wait_irq(rows[i].div, t1);
                chk(t1 - t0 >= rows[i].div / 2 - 2 && t1 - t0 <= rows[i].div / 2 + 2, 1);
                rck(`TICK_CTRL_OFS, cv(rows[i].rate, 1'b0, 1'b1, 1'b1) | 32'h80);
                wck(`TICK_CTRL_OFS, cv(rows[i].rate, 1'b1, 1'b1, 1'b1));
                chk(irq, 1'b0);
                wait_irq(rows[i].div, t2);
                chk(t2 - t1, rows[i].div);
            end
            wck(`TICK_CTRL_OFS, cv(rows[i].rate, 1'b1, 1'b0, 1'b0));
        end
        // Pending bit not writable; stopped divider never ticks
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b1, 1'b0) | 32'h80);
        rck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b1, 1'b0));
        wait_irq(40, t1);
        chk(t1, -1);
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b0, 1'b1));
        wait_irq(20, t1);
        chk(t1, -1);
        rck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b0, 1'b1) | 32'h80);
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b1, 1'b1));
        chk(irq, 1'b1);
        // Status event through the mask, then wait mode
        // Divider stopped so no tick can refill the status bit
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b1, 1'b0, 1'b0));
        wck(`TICK_MASK_OFS, 32'h1);
        rck(`TICK_MASK_OFS, 32'h1);
        wait_irq(20, t1);
        chk(t1 >= 0, 1);
        rck(`TICK_STAT_OFS, 32'h1);
        chk(irq, 1'b0);
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b0, 1'b1));
        wait_m <= 1'b1;
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b0, 1'b0), `TICK_RESP_SLVERR);
        rck(`TICK_CTRL_OFS, 32'h0, `TICK_RESP_SLVERR);
        wait_irq(20, t1);
        chk(t1 >= 0, 1);
        wait_m <= 1'b0;
        rck(`TICK_CTRL_OFS, cv(3'h7, 1'b0, 1'b0, 1'b1) | 32'h80);
        wck(`TICK_MASK_OFS, 32'h0);
        rck(`TICK_STAT_OFS, 32'h1);
        wait_irq(20, t1);
        chk(t1, -1);
        // Stop without the oscillator kept: frozen, no access
        wck(`TICK_CTRL_OFS, cv(3'h7, 1'b1, 1'b0, 1'b0));
        wck(`TICK_CTRL_OFS, cv(3'h4, 1'b1, 1'b1, 1'b0));
        wck(`TICK_CTRL_OFS, cv(3'h4, 1'b0, 1'b1, 1'b1));
        stop_m <= 1'b1;
        rck(`TICK_OPT_OFS, 32'h0, `TICK_RESP_SLVERR);
        wait_irq(60, t1);
        chk(t1, -1);
        chk(wakes, 0);
        stop_m <= 1'b0;
        // Stop with the oscillator kept: ticks and wakes
        wck(`TICK_OPT_OFS, 32'h1);
        wck(`TICK_CTRL_OFS, cv(3'h4, 1'b1, 1'b1, 1'b0));
        wck(`TICK_CTRL_OFS, cv(3'h4, 1'b0, 1'b1, 1'b1));
        stop_m <= 1'b1;
        wait_irq(60, t1);
        chk(t1 >= 0, 1);
        repeat (4) @(posedge mclk);
        chk(wakes, 1);
        stop_m <= 1'b0;
        // Write without byte strobe leaves control untouched
        wck(`TICK_CTRL_OFS, cv(3'h4, 1'b1, 1'b0, 1'b0), `TICK_RESP_OKAY, 4'h0);
        rck(`TICK_CTRL_OFS, cv(3'h4, 1'b0, 1'b1, 1'b1) | 32'h80);
        // Mid-run reset clears enable, run and request
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        chk(irq, 1'b0);
        rck(`TICK_CTRL_OFS, 32'h0);
        // Unmapped address refused
        rck(8'h10, 32'h0, `TICK_RESP_SLVERR);
        wck(8'h10, 32'hFF, `TICK_RESP_SLVERR);
        end_sim();
    end
endmodule
